// file: bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import fbcx_pkg::*;
   logic clk_sys, rst, clk_en, instr_valid;
   fbcx_instr_t instr;
   logic [3:0] p0_in, acc, l_reg, page_buffer, page_address_reg, p3_out;
   logic [2:0] h_reg;
   logic cond_exec_flag, compare_latch;
   logic [9:0] pc, return_stack_reg;
   logic [15:0] p2_out;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   fbcx_core u_fbcx_core (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .instr_valid(instr_valid),
      .instr(instr), .p0_in(p0_in), .acc(acc), .l_reg(l_reg), .h_reg(h_reg),
      .cond_exec_flag(cond_exec_flag), .compare_latch(compare_latch), .page_buffer(page_buffer),
      .page_address_reg(page_address_reg), .pc(pc), .return_stack_reg(return_stack_reg),
      .p3_out(p3_out), .p2_out(p2_out));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic results();
      if (errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watchdog: count an error and finish if the run reaches cycle 3000
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         results();
      end
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One executed instruction, held valid for one cycle; returns at the next falling edge with outputs settled
   task automatic ex(input fbcx_op_t op, input logic [3:0] imm = 4'h0, input logic [1:0] b = 2'h0,
                     input logic [5:0] t = 6'h00);
      @(negedge clk_sys);
      instr = {op, imm, b, t};
      instr_valid = 1'b1;
      @(negedge clk_sys);
      instr_valid = 1'b0;
   endtask
   task automatic ld_a(input logic [3:0] v);
      p0_in = v;
      ex(OP_IN);
   endtask
   task automatic rd(input logic [3:0] l);
      ex(OP_MOV_LI, l);
      ex(OP_MOV_AM);
   endtask
   task automatic t_reset();
      chk("acc", acc, 16'h0000);
      chk("flag", cond_exec_flag, 16'h0001);
      chk("latch", compare_latch, 16'h0001);
      chk("pb", page_buffer, 16'h000F);
      chk("pa", page_address_reg, 16'h000F);
      chk("pc", pc, 16'h0000);
      chk("p3", p3_out, 16'h0000);
      chk("p2", p2_out, 16'h0000);
   endtask
   task automatic t_jump();
      ex(OP_PAGE, 4'h3);
      chk("pb", page_buffer, 16'h0003);
      chk("pa", page_address_reg, 16'h000F);
      ex(OP_JUMP, 4'h0, 2'h0, 6'h05);
      chk("pc", pc, 16'h00C5);
      chk("pa", page_address_reg, 16'h0003);
      ex(OP_CALL, 4'h0, 2'h0, 6'h10);
      chk("pc", pc, 16'h00D0);
      chk("sr", return_stack_reg, 16'h00C6);
      ex(OP_RET);
      chk("pc", pc, 16'h00C6);
      ex(OP_PAGE, 4'h5);
      ex(OP_MOV_HI, 4'h0);
      ex(OP_MOV_LI, 4'h0);
      ld_a(4'h0);
      ex(OP_MOV_MA);
      ex(OP_CMP_MA);
      chk("flag", cond_exec_flag, 16'h0000);
      ex(OP_JUMP, 4'h0, 2'h0, 6'h09);
      chk("flag", cond_exec_flag, 16'h0001);
      chk("pa", page_address_reg, 16'h0003);
      chk("pc", pc, 16'h00CD);
      ex(OP_JUMP, 4'h0, 2'h0, 6'h09);
      chk("pc", pc, 16'h0149);
   endtask
   task automatic t_store();
      ex(OP_MOV_LI, 4'hF);
      ld_a(4'h5);
      ex(OP_STORE_INC);
      chk("l", l_reg, 16'h0000);
      chk("flag", cond_exec_flag, 16'h0001);
      ex(OP_STORE_INC);
      chk("flag", cond_exec_flag, 16'h0000);
      rd(4'hF);
      chk("acc", acc, 16'h0005);
      ld_a(4'h6);
      ex(OP_MOV_LI, 4'h0);
      ex(OP_STORE_DEC);
      chk("l", l_reg, 16'h000F);
      chk("flag", cond_exec_flag, 16'h0000);
      ex(OP_STORE_DEC);
      chk("flag", cond_exec_flag, 16'h0001);
      rd(4'h0);
      chk("acc", acc, 16'h0006);
      ex(OP_MOV_LI, 4'h7);
      ex(OP_STORE_IMM_INC, 4'h9);
      chk("l", l_reg, 16'h0008);
      rd(4'h7);
      chk("acc", acc, 16'h0009);
      ld_a(4'h3);
      ex(OP_MOV_LI, 4'h2);
      ex(OP_STORE_CLEAR);
      chk("acc", acc, 16'h0000);
      ex(OP_MOV_AM);
      chk("acc", acc, 16'h0003);
      ld_a(4'h6);
      ex(OP_EXCHANGE);
      chk("acc", acc, 16'h0003);
      ex(OP_MOV_AM);
      chk("acc", acc, 16'h0006);
   endtask
   task automatic t_cmp();
      ex(OP_CMP_MA);
      chk("flag", cond_exec_flag, 16'h0000);
      ld_a(4'h7);
      ex(OP_CMP_MA);
      chk("flag", cond_exec_flag, 16'h0001);
      chk("acc", acc, 16'h0007);
      ld_a(4'h2);
      ex(OP_CMP_LA);
      chk("latch", compare_latch, 16'h0000);
      chk("flag", cond_exec_flag, 16'h0000);
      ex(OP_CMP_MA);
      ex(OP_ADD_I, 4'h1);
      ex(OP_NOT_H);
      ex(OP_OUT);
      chk("latch", compare_latch, 16'h0000);
      ex(OP_NOT_H);
      ex(OP_CMP_LA);
      chk("latch", compare_latch, 16'h0001);
      chk("flag", cond_exec_flag, 16'h0001);
      ex(OP_CMP_LI, 4'h2);
      chk("flag", cond_exec_flag, 16'h0000);
      ex(OP_CMP_LI, 4'h3);
      chk("flag", cond_exec_flag, 16'h0001);
      for (int b = 0; b < 4; b++) begin
         ex(OP_BIT_TEST, 4'h0, 2'(b));
         chk("flag", cond_exec_flag, 16'((16'h0006 >> b) & 16'h0001));
      end
   endtask
   task automatic t_alu();
      ld_a(4'h5);
      ex(OP_COMPLEMENT_INC);
      chk("acc", acc, 16'h000B);
      ex(OP_MOV_HI, 4'h1);
      ex(OP_NOT_H);
      chk("h", h_reg, 16'h0005);
      ex(OP_MOV_HI, 4'h0);
      ld_a(4'h2);
      ex(OP_SUB_M);
      chk("acc", acc, 16'h0004);
      ex(OP_INC_M);
      chk("acc", acc, 16'h0007);
      ex(OP_DEC_M);
      chk("acc", acc, 16'h0005);
      ld_a(4'h3);
      ex(OP_ADD_M);
      chk("acc", acc, 16'h0009);
      ex(OP_ADD_I, 4'h8);
      chk("acc", acc, 16'h0001);
      ex(OP_BIT_SET, 4'h0, 2'h0);
      ex(OP_MOV_AM);
      chk("acc", acc, 16'h0007);
      ex(OP_BIT_CLEAR, 4'h0, 2'h2);
      ex(OP_MOV_AM);
      chk("acc", acc, 16'h0003);
      ld_a(4'hA);
      ex(OP_OUT);
      chk("p3", p3_out, 16'h000A);
      clk_en = 1'b0;
      ld_a(4'h4);
      chk("acc", acc, 16'h000A);
      clk_en = 1'b1;
   endtask
   task automatic t_misc();
      ex(OP_CLR_A);
      chk("acc", acc, 16'h0000);
      ex(OP_DEC_A);
      chk("acc", acc, 16'h000F);
      chk("flag", cond_exec_flag, 16'h0000);
      ex(OP_INC_A);
      chk("acc", acc, 16'h0000);
      chk("flag", cond_exec_flag, 16'h0001);
      ex(OP_MOV_LA);
      ex(OP_DEC_L);
      chk("l", l_reg, 16'h000F);
      chk("flag", cond_exec_flag, 16'h0000);
      ex(OP_INC_L);
      chk("l", l_reg, 16'h0000);
      chk("flag", cond_exec_flag, 16'h0001);
      ex(OP_MOV_LM);
      chk("l", l_reg, 16'h0006);
      ex(OP_MOV_AL);
      chk("acc", acc, 16'h0006);
      ex(OP_P2_SET);
      ex(OP_MOV_LI, 4'hD);
      ex(OP_P2_SET);
      chk("p2", p2_out, 16'h2040);
      ex(OP_MOV_LI, 4'h6);
      ex(OP_P2_CLR);
      chk("p2", p2_out, 16'h2000);
      ex(OP_MOV_LI, 4'h2);
      ex(OP_CMP_LE);
      chk("flag", cond_exec_flag, 16'h0000);
      ex(OP_MOV_AL);
      ex(OP_CMP_LE);
      chk("flag", cond_exec_flag, 16'h0001);
      ex(OP_CLR_A);
      ex(OP_MOV_MA);
      ex(OP_CMP_MZ);
      chk("flag", cond_exec_flag, 16'h0000);
      ex(OP_NOP);
      chk("flag", cond_exec_flag, 16'h0001);
      p0_in = 4'h4;
      ex(OP_CMP_P0Z);
      chk("flag", cond_exec_flag, 16'h0001);
      p0_in = 4'h0;
      ex(OP_CMP_P0Z);
      chk("flag", cond_exec_flag, 16'h0000);
      ex(OP_CALL, 4'h0, 2'h0, 6'h3F);
      chk("flag", cond_exec_flag, 16'h0001);
      chk("sr", return_stack_reg, 16'h00C6);
      chk("latch", compare_latch, 16'h0001);
      rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      t_reset();
   endtask
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      instr_valid = 1'b0;
      instr = '0;
      p0_in = 4'h0;
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      t_reset();
      t_jump();
      t_store();
      t_cmp();
      t_alu();
      t_misc();
      results();
   end
endmodule
`default_nettype wire

// file: rtl/fbcx_core.sv
`include "fbcx_params.svh"
`timescale 1ns/1ns
`default_nettype none
module fbcx_core #(
   parameter int RAM_WORDS = `FBCX_RAM_WORDS
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic instr_valid,
   input wire fbcx_pkg::fbcx_instr_t instr,
   input wire logic [3:0] p0_in,
   output logic [3:0] acc,
   output logic [3:0] l_reg,
   output logic [2:0] h_reg,
   output logic cond_exec_flag,
   output logic compare_latch,
   output logic [3:0] page_buffer,
   output logic [3:0] page_address_reg,
   output logic [9:0] pc,
   output logic [9:0] return_stack_reg,
   output logic [3:0] p3_out,
   output logic [15:0] p2_out
);
   import fbcx_pkg::*;

   function automatic logic [4:0] add5(input logic [3:0] x, input logic [3:0] y);
      add5 = {1'b0, x} + {1'b0, y};
   endfunction

   function automatic logic [4:0] sub5(input logic [3:0] x, input logic [3:0] y);
      sub5 = {1'b0, x} - {1'b0, y};
   endfunction

   logic [3:0] ram [RAM_WORDS];
   logic [3:0] next_acc;
   logic [3:0] next_l;
   logic [2:0] next_h;
   logic next_flag;
   logic next_latch;
   logic [3:0] next_page_buffer;
   logic [3:0] next_page_address;
   logic [9:0] next_pc;
   logic [9:0] next_sr;
   logic [3:0] next_p3;
   logic [15:0] next_p2;
   logic ram_we;
   logic [3:0] ram_wdata;

   wire [4:0] ram_addr = {h_reg[0], l_reg};
   wire [3:0] mem = ram[ram_addr];
   wire [4:0] sum_m = add5(acc, mem);
   wire [4:0] sum_i = add5(acc, instr.imm);
   wire [4:0] diff_m = sub5(mem, acc);
   wire [4:0] inc_m = add5(mem, 4'h1);
   wire [4:0] dec_m = sub5(mem, 4'h1);
   wire [4:0] inc_l = add5(l_reg, 4'h1);
   wire [4:0] dec_l = sub5(l_reg, 4'h1);
   wire [4:0] inc_a = add5(acc, 4'h1);
   wire [4:0] dec_a = sub5(acc, 4'h1);
   wire [4:0] neg_a = add5(~acc, 4'h1);
   wire [9:0] seq_pc = pc + 10'h001;
   wire [9:0] jump_pc = {page_buffer, instr.target};
   wire is_branch = (instr.op == OP_JUMP) || (instr.op == OP_CALL);
   wire [3:0] bit_mask = 4'h1 << instr.bit_sel;

   always_comb begin
      next_acc = acc;
      next_l = l_reg;
      next_h = h_reg;
      next_flag = 1'b1;
      next_latch = compare_latch;
      next_page_buffer = page_buffer;
      next_page_address = page_address_reg;
      next_pc = seq_pc;
      next_sr = return_stack_reg;
      next_p3 = p3_out;
      next_p2 = p2_out;
      ram_we = 1'b0;
      ram_wdata = acc;
      unique case (instr.op)
         OP_NOP: begin
         end
         OP_MOV_LA: next_l = acc;
         OP_MOV_AL: next_acc = l_reg;
         OP_MOV_MA: ram_we = 1'b1;
         OP_MOV_AM: next_acc = mem;
         OP_MOV_LM: next_l = mem;
         OP_STORE_INC: begin
            ram_we = 1'b1;
            next_l = inc_l[3:0];
            next_flag = inc_l[4];
         end
         OP_STORE_DEC: begin
            ram_we = 1'b1;
            next_l = dec_l[3:0];
            next_flag = ~dec_l[4];
         end
         OP_MOV_LI: next_l = instr.imm;
         OP_MOV_HI: next_h = instr.imm[2:0];
         OP_STORE_IMM_INC: begin
            ram_we = 1'b1;
            ram_wdata = instr.imm;
            next_l = inc_l[3:0];
         end
         OP_STORE_CLEAR: begin
            ram_we = 1'b1;
            next_acc = 4'h0;
         end
         OP_EXCHANGE: begin
            ram_we = 1'b1;
            next_acc = mem;
         end
         OP_PAGE: next_page_buffer = instr.imm;
         OP_CMP_MA: next_flag = (mem != acc);
         OP_CMP_MZ: next_flag = (mem != 4'h0);
         OP_CMP_LA: begin
            next_flag = (l_reg != acc);
            next_latch = (l_reg != acc);
         end
         OP_CMP_LI: next_flag = (l_reg != instr.imm);
         OP_CMP_LE: next_flag = (acc <= mem);
         OP_CMP_P0Z: next_flag = (p0_in != 4'h0);
         OP_BIT_TEST: next_flag = |(mem & bit_mask);
         OP_JUMP, OP_CALL: begin
            if (cond_exec_flag) begin
               next_pc = jump_pc;
               next_page_address = page_buffer;
               if (instr.op == OP_CALL) begin
                  next_sr = seq_pc;
               end
            end
         end
         OP_RET: begin
            next_pc = return_stack_reg;
            next_page_address = return_stack_reg[9:6];
            next_page_buffer = return_stack_reg[9:6];
         end
         OP_P2_SET: next_p2[l_reg] = 1'b1;
         OP_P2_CLR: next_p2[l_reg] = 1'b0;
         OP_IN: next_acc = p0_in;
         OP_OUT: next_p3 = acc;
         OP_COMPLEMENT_INC: begin
            next_acc = neg_a[3:0];
            next_flag = (neg_a[3:0] != 4'h0);
         end
         OP_NOT_H: next_h = h_reg ^ 3'(1 << `FBCX_H_MSB);
         OP_CLR_A: next_acc = 4'h0;
         OP_ADD_M: begin
            next_acc = sum_m[3:0];
            next_flag = sum_m[4];
         end
         OP_ADD_I: begin
            next_acc = sum_i[3:0];
            next_flag = sum_i[4];
         end
         OP_SUB_M: begin
            next_acc = diff_m[3:0];
            next_flag = ~diff_m[4];
         end
         OP_INC_M: begin
            next_acc = inc_m[3:0];
            next_flag = inc_m[4];
         end
         OP_DEC_M: begin
            next_acc = dec_m[3:0];
            next_flag = ~dec_m[4];
         end
         OP_INC_L: begin
            next_l = inc_l[3:0];
            next_flag = inc_l[4];
         end
         OP_DEC_L: begin
            next_l = dec_l[3:0];
            next_flag = ~dec_l[4];
         end
         OP_INC_A: begin
            next_acc = inc_a[3:0];
            next_flag = inc_a[4];
         end
         OP_DEC_A: begin
            next_acc = dec_a[3:0];
            next_flag = ~dec_a[4];
         end
         OP_BIT_SET: begin
            ram_we = 1'b1;
            ram_wdata = mem | bit_mask;
         end
         OP_BIT_CLEAR: begin
            ram_we = 1'b1;
            ram_wdata = mem & ~bit_mask;
         end
         default: begin
         end
      endcase
   end

   wire step = clk_en && instr_valid;

   always_ff @(posedge clk_sys) begin
      if (step && ram_we) begin
         ram[ram_addr] <= ram_wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         acc <= 4'h0;
         l_reg <= 4'h0;
         h_reg <= 3'h0;
         cond_exec_flag <= 1'b1;
         compare_latch <= 1'b1;
         page_buffer <= `FBCX_PAGE_RESET;
         page_address_reg <= `FBCX_PAGE_RESET;
         pc <= `FBCX_PC_RESET;
         return_stack_reg <= `FBCX_SR_RESET;
         p3_out <= 4'h0;
         p2_out <= 16'h0000;
      end else if (step) begin
         acc <= next_acc;
         l_reg <= next_l;
         h_reg <= next_h;
         cond_exec_flag <= next_flag;
         compare_latch <= next_latch;
         page_buffer <= next_page_buffer;
         page_address_reg <= next_page_address;
         pc <= next_pc;
         return_stack_reg <= next_sr;
         p3_out <= next_p3;
         p2_out <= next_p2;
      end
   end

   AST_BRANCH_TAKEN: assert property (@(posedge clk_sys) disable iff (rst)
      step && is_branch && cond_exec_flag |=> pc == $past(jump_pc))
      else $error("branch not taken with flag high");
   AST_BRANCH_SKIP: assert property (@(posedge clk_sys) disable iff (rst)
      step && is_branch && !cond_exec_flag |=> cond_exec_flag && pc == $past(seq_pc))
      else $error("skipped branch misbehaved");
   AST_SKIP_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      step && is_branch && !cond_exec_flag |=> $stable(page_address_reg) && $stable(return_stack_reg))
      else $error("skipped branch changed page or stack");
   AST_PAGE_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_PAGE |=> page_buffer == $past(instr.imm))
      else $error("page buffer not loaded");
   AST_PAGE_FOLLOW: assert property (@(posedge clk_sys) disable iff (rst)
      step && is_branch && cond_exec_flag |=> page_address_reg == $past(page_buffer))
      else $error("page address not updated");
   AST_PAGE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      step && !is_branch && instr.op != OP_RET |=> $stable(page_address_reg))
      else $error("page address changed without branch");
   AST_CALL_SAVE: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_CALL && cond_exec_flag |=> return_stack_reg == $past(seq_pc))
      else $error("call did not save return address");
   AST_STORE_INC: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_STORE_INC |=> l_reg == $past(inc_l[3:0]) && cond_exec_flag == $past(inc_l[4]))
      else $error("store increment wrong");
   AST_STORE_INC_WR: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_STORE_INC |=> ram[$past(ram_addr)] == $past(acc))
      else $error("store increment did not write");
   AST_STORE_DEC: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_STORE_DEC |=> l_reg == $past(dec_l[3:0]) && cond_exec_flag == !$past(dec_l[4]))
      else $error("store decrement wrong");
   AST_STORE_DEC_WR: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_STORE_DEC |=> ram[$past(ram_addr)] == $past(acc))
      else $error("store decrement did not write");
   AST_STORE_IMM: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_STORE_IMM_INC |=> ram[$past(ram_addr)] == $past(instr.imm)
         && l_reg == 4'($past(l_reg) + 4'h1))
      else $error("immediate store wrong");
   AST_STORE_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_STORE_CLEAR |=> acc == 4'h0 && ram[$past(ram_addr)] == $past(acc))
      else $error("store clear wrong");
   AST_EXCHANGE: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_EXCHANGE |=> acc == $past(mem) && ram[$past(ram_addr)] == $past(acc))
      else $error("exchange wrong");
   AST_CMP_MA: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_CMP_MA |=> cond_exec_flag == ($past(mem) != $past(acc)) && $stable(acc))
      else $error("RAM compare wrong");
   AST_LATCH_ONLY: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op != OP_CMP_LA |=> $stable(compare_latch))
      else $error("latch changed by other instruction");
   AST_CMP_LA: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_CMP_LA |=> compare_latch == ($past(l_reg) != $past(acc)))
      else $error("latch compare wrong");
   AST_CMP_LI: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_CMP_LI |=> cond_exec_flag == ($past(l_reg) != $past(instr.imm)))
      else $error("immediate compare wrong");
   AST_BIT_TEST: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_BIT_TEST |=> cond_exec_flag == $past(mem[instr.bit_sel]))
      else $error("bit test wrong");
   AST_NEG: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_COMPLEMENT_INC |=> acc == 4'(0 - $past(acc)))
      else $error("two's complement wrong");
   AST_SUB: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_SUB_M |=> acc == 4'($past(mem) - $past(acc)))
      else $error("subtract wrong");
   AST_INC_M: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_INC_M |=> acc == 4'($past(mem) + 4'h1))
      else $error("RAM increment wrong");
   AST_DEC_M: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_DEC_M |=> acc == 4'($past(mem) - 4'h1))
      else $error("RAM decrement wrong");
   AST_ADD_M: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_ADD_M |=> acc == 4'($past(acc) + $past(mem)))
      else $error("RAM add wrong");
   AST_ADD_I: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_ADD_I |=> acc == 4'($past(acc) + $past(instr.imm)))
      else $error("immediate add wrong");
   AST_BIT_SET: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_BIT_SET |=> ram[$past(ram_addr)][$past(instr.bit_sel)])
      else $error("RAM bit set wrong");
   AST_BIT_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_BIT_CLEAR |=> !ram[$past(ram_addr)][$past(instr.bit_sel)])
      else $error("RAM bit clear wrong");
   AST_NOT_H: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_NOT_H |=> h_reg == {~$past(h_reg[2]), $past(h_reg[1:0])})
      else $error("H complement wrong");
   AST_OUT: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_OUT |=> p3_out == $past(acc))
      else $error("output port wrong");
   AST_RET: assert property (@(posedge clk_sys) disable iff (rst)
      step && instr.op == OP_RET |=> pc == $past(return_stack_reg))
      else $error("return wrong");
endmodule
`default_nettype wire

// file: rtl/fbcx_params.svh
`ifndef FBCX_PARAMS_SVH
`define FBCX_PARAMS_SVH
`define FBCX_PAGE_RESET 4'hF
`define FBCX_SR_RESET 10'h000
`define FBCX_PC_RESET 10'h000
`define FBCX_RAM_WORDS 32
`define FBCX_H_MSB 2
`endif

// file: rtl/fbcx_pkg.sv
package fbcx_pkg;
   typedef enum logic [5:0] {
      OP_NOP, OP_MOV_LA, OP_MOV_AL, OP_MOV_MA, OP_MOV_AM, OP_MOV_LM,
      OP_STORE_INC, OP_STORE_DEC, OP_MOV_LI, OP_MOV_HI, OP_STORE_IMM_INC,
      OP_STORE_CLEAR, OP_EXCHANGE, OP_PAGE, OP_CMP_MA, OP_CMP_MZ, OP_CMP_LA,
      OP_CMP_LI, OP_CMP_LE, OP_CMP_P0Z, OP_BIT_TEST, OP_JUMP, OP_CALL, OP_RET,
      OP_P2_SET, OP_P2_CLR, OP_IN, OP_OUT, OP_COMPLEMENT_INC, OP_NOT_H, OP_CLR_A,
      OP_ADD_M, OP_ADD_I, OP_SUB_M, OP_INC_M, OP_INC_L, OP_INC_A, OP_DEC_A,
      OP_DEC_M, OP_DEC_L, OP_BIT_SET, OP_BIT_CLEAR
   } fbcx_op_t;
   typedef struct packed {
      fbcx_op_t op;
      logic [3:0] imm;
      logic [1:0] bit_sel;
      logic [5:0] target;
   } fbcx_instr_t;
   typedef struct packed {
      logic [9:0] pc;
      logic [3:0] page;
   } fbcx_fetch_t;
endpackage
